/* File: poc_defines.svh */
`ifndef POC_DEFINES_SVH
`define POC_DEFINES_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define POC_IDX_PULSE_CFG 16'he610
`define POC_IDX_PHASE_A 16'he614
`define POC_IDX_PHASE_B 16'he615
`define POC_IDX_PHASE_C 16'he616
`define POC_IDX_COMP_MODE 16'he620
`define POC_IDX_STATUS 16'he621

// ----------------------------------------
// pulse_output_config fields
// ----------------------------------------
`define POC_SEL1_LSB 0
`define POC_SEL2_LSB 3
`define POC_SEL3_LSB 6
`define POC_OFF_LSB 9
`define POC_CAP_LSB 12
`define POC_CFG_RSVD_BIT 15
`define POC_CFG_W 15
`define POC_CFG_RST 15'h0ea0

// ----------------------------------------
// computation_mode_reg and phase compensation
// ----------------------------------------
`define POC_MODE_W 9
`define POC_MODE_RST 9'h1ff
`define POC_PHC_W 10
`define POC_PHC_RST 10'h000
`define POC_PHC_LEAD_MAX 10'h17f
`define POC_PHC_ALIAS1_LO 10'h180
`define POC_PHC_LAG_LO 10'h200
`define POC_PHC_LAG_HI 10'h23f
`define POC_PHC_ALIAS2_LO 10'h240
`define POC_PHC_ALIAS1_TOP 3'h2
`define POC_PHC_ALIAS2_TOP 3'h3

`endif

/* File: poc_host.sv */
`timescale 1ns/10ps
// --------------------------------
// ahb-lite single-word master
// --------------------------------
module poc_host (
  input wire logic clk_sys,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* File: poc_pkg.sv */
package poc_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RDWAIT = 2'b10
  } poc_bus_t;

  typedef enum logic [2:0] {
    SRC_TOT_ACT = 3'h0,
    SRC_APPARENT = 3'h2,
    SRC_FUND_ACT = 3'h3,
    SRC_FUND_REACT = 3'h4
  } poc_src_t;

endpackage

/* File: poc_top.sv */
`timescale 1ns/10ps
`include "poc_defines.svh"

// Notes on behaviour
// - path 1 source code, bits 2:0, reset 000
// - path 2 source code, bits 5:3, reset 100
// - path 3 source code, bits 8:6, reset 010
// - phase inclusion bits pick summed phases
// - bits 11:9 disable pins, reset 1
// - converter keeps running while pin disabled
// - bits 14:12 capture energy on pulse
// - config bit 15 reserved, reads zero
// - compensation 9:0, 0..383 means lead
// - compensation 512..575 means lag
// - 384..511 acts like 256..383
// - 576..1023 acts like 384..511
// - compensation bits 15:10 reserved, zero
// - set inclusion bit adds its phase
module poc_top #(
  parameter int PWR_W = 24,
  parameter int ACC_W = 32,
  parameter logic [ACC_W-1:0] PULSE_THRESH = 'h10000
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic powerValid,
  input wire logic signed [PWR_W-1:0] totActPwr [3],
  input wire logic signed [PWR_W-1:0] apparentPwr [3],
  input wire logic signed [PWR_W-1:0] fundActPwr [3],
  input wire logic signed [PWR_W-1:0] fundReactPwr [3],
  output logic pulse_out_1,
  output logic pulse_out_2,
  output logic pulse_out_3,
  output logic [2:0] energyCapture,
  output logic [2:0][PWR_W+1:0] pathSum,
  output logic [2:0][`POC_PHC_W-1:0] phaseCompValue,
  output logic [2:0] phaseCompLag
);

  localparam int SUM_W = PWR_W + 2;

  logic [`POC_CFG_W-1:0] cfg_ff;
  logic [`POC_MODE_W-1:0] mode_ff;
  logic [`POC_PHC_W-1:0] phComp_ff [3];
  poc_pkg::poc_bus_t busState_ff;
  logic wrPend_ff;
  logic [15:0] wrIdx_ff;
  logic [15:0] rdIdx_ff;
  logic addrOk_ff;
  logic [31:0] hrdata_ff;
  logic [2:0] pulse_ff;
  logic [2:0] capture_ff;
  logic [2:0] sumSign;
  logic [2:0] dfcHit;
  logic accept;
  logic addrOk;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign accept = hsel && hready && htrans[1];
  assign addrOk = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
  assign hreadyout = (busState_ff != poc_pkg::BUS_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busState_ff <= poc_pkg::BUS_IDLE;
    end else begin
      case (busState_ff)
        poc_pkg::BUS_IDLE: begin
          if (accept && !hwrite) begin
            busState_ff <= poc_pkg::BUS_RDWAIT;
          end
        end
        poc_pkg::BUS_RDWAIT: begin
          busState_ff <= poc_pkg::BUS_IDLE;
        end
        default: begin
          busState_ff <= poc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 16'h0000;
      rdIdx_ff <= 16'h0000;
      addrOk_ff <= 1'b0;
    end else if (hready) begin
      wrPend_ff <= accept && hwrite;
      if (accept) begin
        wrIdx_ff <= haddr[17:2];
        rdIdx_ff <= haddr[17:2];
        addrOk_ff <= addrOk;
      end
    end
  end

  // read data is sampled one cycle late so a preceding write is visible
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (busState_ff == poc_pkg::BUS_RDWAIT) begin
      hrdata_ff <= 32'h0000_0000;
      if (addrOk_ff) begin
        case (rdIdx_ff)
          `POC_IDX_PULSE_CFG: hrdata_ff[`POC_CFG_W-1:0] <= cfg_ff;
          `POC_IDX_PHASE_A: hrdata_ff[`POC_PHC_W-1:0] <= phComp_ff[0];
          `POC_IDX_PHASE_B: hrdata_ff[`POC_PHC_W-1:0] <= phComp_ff[1];
          `POC_IDX_PHASE_C: hrdata_ff[`POC_PHC_W-1:0] <= phComp_ff[2];
          `POC_IDX_COMP_MODE: hrdata_ff[`POC_MODE_W-1:0] <= mode_ff;
          `POC_IDX_STATUS: hrdata_ff[2:0] <= sumSign;
          default: hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // source code reset values
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_ff <= `POC_CFG_RST;
    end else if (wrPend_ff && addrOk_ff && wrIdx_ff == `POC_IDX_PULSE_CFG) begin
      cfg_ff <= hwdata[`POC_CFG_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_ff <= `POC_MODE_RST;
    end else if (wrPend_ff && addrOk_ff && wrIdx_ff == `POC_IDX_COMP_MODE) begin
      mode_ff <= hwdata[`POC_MODE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phComp_ff[0] <= `POC_PHC_RST;
      phComp_ff[1] <= `POC_PHC_RST;
      phComp_ff[2] <= `POC_PHC_RST;
    end else if (wrPend_ff && addrOk_ff) begin
      if (wrIdx_ff == `POC_IDX_PHASE_A) phComp_ff[0] <= hwdata[`POC_PHC_W-1:0];
      if (wrIdx_ff == `POC_IDX_PHASE_B) phComp_ff[1] <= hwdata[`POC_PHC_W-1:0];
      if (wrIdx_ff == `POC_IDX_PHASE_C) phComp_ff[2] <= hwdata[`POC_PHC_W-1:0];
    end
  end

  // ----------------------------------------
  // pulse paths
  // ----------------------------------------
  for (genvar p = 0; p < 3; p++) begin : g_path
    logic [2:0] srcSel;
    logic [2:0] phInc;
    logic signed [SUM_W-1:0] nxt_sum;
    logic signed [SUM_W-1:0] sum_ff;
    logic sumValid_ff;
    logic [SUM_W-1:0] mag;
    logic [ACC_W-1:0] accSum;
    logic [ACC_W-1:0] acc_ff;

    assign srcSel = cfg_ff[3*p +: 3];
    assign phInc = mode_ff[3*p +: 3];

    // sum only included phases of chosen quantity
    always_comb begin
      nxt_sum = '0;
      for (int ph = 0; ph < 3; ph++) begin
        // a set bit adds that phase
        if (phInc[ph]) begin
          case (srcSel)
            poc_pkg::SRC_TOT_ACT: nxt_sum = nxt_sum + SUM_W'(totActPwr[ph]);
            poc_pkg::SRC_APPARENT: nxt_sum = nxt_sum + SUM_W'(apparentPwr[ph]);
            poc_pkg::SRC_FUND_ACT: nxt_sum = nxt_sum + SUM_W'(fundActPwr[ph]);
            poc_pkg::SRC_FUND_REACT: nxt_sum = nxt_sum + SUM_W'(fundReactPwr[ph]);
            default: nxt_sum = nxt_sum;
          endcase
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        sum_ff <= '0;
        sumValid_ff <= 1'b0;
      end else begin
        sumValid_ff <= powerValid;
        if (powerValid) sum_ff <= nxt_sum;
      end
    end

    assign mag = sum_ff[SUM_W-1] ? SUM_W'(-sum_ff) : SUM_W'(sum_ff);
    assign accSum = acc_ff + ACC_W'(mag);
    assign dfcHit[p] = sumValid_ff && (accSum >= PULSE_THRESH);

    // converter runs regardless of pin disable
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        acc_ff <= '0;
      end else if (sumValid_ff) begin
        acc_ff <= dfcHit[p] ? accSum - PULSE_THRESH : accSum;
      end
    end

    // disable bit gates only the pin
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        pulse_ff[p] <= 1'b0;
      end else begin
        pulse_ff[p] <= dfcHit[p] && !cfg_ff[`POC_OFF_LSB + p];
      end
    end

    // capture strobe on each converter pulse
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        capture_ff[p] <= 1'b0;
      end else begin
        capture_ff[p] <= dfcHit[p] && cfg_ff[`POC_CAP_LSB + p];
      end
    end

    assign sumSign[p] = sum_ff[SUM_W-1];
    assign pathSum[p] = sum_ff;
  end

  assign pulse_out_1 = pulse_ff[0];
  assign pulse_out_2 = pulse_ff[1];
  assign pulse_out_3 = pulse_ff[2];
  assign energyCapture = capture_ff;

  // ----------------------------------------
  // phase compensation decode
  // ----------------------------------------
  for (genvar k = 0; k < 3; k++) begin : g_phase
    logic [`POC_PHC_W-1:0] v;
    logic [`POC_PHC_W-1:0] nxt_eff;
    logic [`POC_PHC_W-1:0] eff_ff;
    logic lag_ff;

    assign v = phComp_ff[k];

    always_comb begin
      nxt_eff = v;
      // codes 384..511 fold down by 128, codes from 576 fold into 384..511
      if (v >= `POC_PHC_ALIAS1_LO && v < `POC_PHC_LAG_LO) begin
        nxt_eff = {`POC_PHC_ALIAS1_TOP, v[6:0]};
      end else if (v >= `POC_PHC_ALIAS2_LO) begin
        nxt_eff = {`POC_PHC_ALIAS2_TOP, v[6:0]};
      end
    end

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        eff_ff <= `POC_PHC_RST;
        lag_ff <= 1'b0;
      end else begin
        eff_ff <= nxt_eff;
        lag_ff <= (v >= `POC_PHC_LAG_LO) && (v <= `POC_PHC_LAG_HI);
      end
    end

    assign phaseCompValue[k] = eff_ff;
    assign phaseCompLag[k] = lag_ff;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_sel1_reset: assert property (@(posedge clk_sys) $fell(srst) |-> cfg_ff[2:0] == 3'h0)
    else $error("path 1 source reset wrong");
  a_sel2_reset: assert property (@(posedge clk_sys) $fell(srst) |-> cfg_ff[5:3] == 3'h4)
    else $error("path 2 source reset wrong");
  a_sel3_reset: assert property (@(posedge clk_sys) $fell(srst) |-> cfg_ff[8:6] == 3'h2)
    else $error("path 3 source reset wrong");
  a_include_none: assert property (powerValid && mode_ff[2:0] == 3'h0 |=> pathSum[0] == '0)
    else $error("excluded phases entered sum");
  a_include_all: assert property (powerValid && mode_ff[2:0] == 3'h7 && cfg_ff[2:0] == 3'h0 |=>
    pathSum[0] == SUM_W'($past(totActPwr[0])) + SUM_W'($past(totActPwr[1])) + SUM_W'($past(totActPwr[2])))
    else $error("all-phase sum wrong");
  a_off_reset: assert property ($fell(srst) |-> cfg_ff[11:9] == 3'h7 ##1 !pulse_out_1)
    else $error("disable bits not set at reset");
  a_dfc_running: assert property (g_path[0].sumValid_ff && cfg_ff[9] && g_path[0].mag != '0 |=>
    g_path[0].acc_ff != $past(g_path[0].acc_ff) || $past(dfcHit[0]))
    else $error("converter stalled while disabled");
  a_capture_pulse: assert property (dfcHit[1] && cfg_ff[13] |=>
    energyCapture[1] ##1 (!energyCapture[1] || $past(dfcHit[1] && cfg_ff[13])))
    else $error("capture strobe missing");
  a_cfg_rsvd: assert property (busState_ff == poc_pkg::BUS_RDWAIT && rdIdx_ff == `POC_IDX_PULSE_CFG |=>
    hrdata[31:15] == '0)
    else $error("reserved config bit read nonzero");
  a_comp_lead: assert property (phComp_ff[0] <= `POC_PHC_LEAD_MAX |=> $stable(phComp_ff[0]) |->
    phaseCompValue[0] == phComp_ff[0] && !phaseCompLag[0])
    else $error("lead value altered");
  a_comp_lag: assert property (phComp_ff[1] >= `POC_PHC_LAG_LO && phComp_ff[1] <= `POC_PHC_LAG_HI |=>
    phaseCompLag[1] && phaseCompValue[1] == $past(phComp_ff[1]))
    else $error("lag value not flagged");
  a_comp_alias1: assert property (phComp_ff[2] >= `POC_PHC_ALIAS1_LO && phComp_ff[2] < `POC_PHC_LAG_LO |=>
    phaseCompValue[2] == $past(phComp_ff[2]) - 10'h080)
    else $error("first alias wrong");
  a_comp_alias2: assert property (phComp_ff[0] >= `POC_PHC_ALIAS2_LO |=>
    phaseCompValue[0] >= `POC_PHC_ALIAS1_LO && phaseCompValue[0] < `POC_PHC_LAG_LO && !phaseCompLag[0])
    else $error("second alias wrong");
  a_comp_rsvd: assert property (busState_ff == poc_pkg::BUS_RDWAIT && rdIdx_ff == `POC_IDX_PHASE_B |=>
    hrdata[31:10] == '0 && hreadyout)
    else $error("reserved compensation bits nonzero");
  a_off_quiet: assert property (cfg_ff[10] |=> !pulse_out_2)
    else $error("disabled pin pulsed");
  c_pulse1: cover property (pulse_out_1);
  c_capture3: cover property (energyCapture[2]);
  c_read_wait: cover property (!hreadyout ##1 hreadyout);
  c_cfg_write: cover property (wrPend_ff && wrIdx_ff == `POC_IDX_PULSE_CFG);
endmodule

/* File: tb_pulse_output_and_phase_cal_config.sv */
`timescale 1ns/10ps
`include "poc_defines.svh"
module tb_pulse_output_and_phase_cal_config;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic powerValid = 1'b0;
  logic cntOn = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic signed [23:0] totActPwr [3], apparentPwr [3], fundActPwr [3], fundReactPwr [3];
  logic pulse_out_1, pulse_out_2, pulse_out_3;
  logic [2:0] energyCapture, phaseCompLag;
  logic [2:0][25:0] pathSum;
  logic [2:0][9:0] phaseCompValue;
  logic [31:0] pulseCnt [3], capCnt [3];
  int n_mismatch = 0;
  int check_count = 0;
  wire logic [2:0] pins = {pulse_out_3, pulse_out_2, pulse_out_1};
  localparam logic [9:0] TV [8] = '{10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f, 10'h240, 10'h3ff, 10'h0};
  localparam logic [9:0] TE [8] = '{10'h17f, 10'h100, 10'h17f, 10'h200, 10'h23f, 10'h1c0, 10'h1ff, 10'h0};
  localparam logic [7:0] TL = 8'b0001_1000;

  always #2.5 clk_sys = ~clk_sys;

  poc_host i_host (.clk_sys(clk_sys), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  poc_top #(.PWR_W(24), .ACC_W(32), .PULSE_THRESH(32'h4)) i_dut (.clk_sys(clk_sys), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerValid(powerValid),
    .totActPwr(totActPwr), .apparentPwr(apparentPwr), .fundActPwr(fundActPwr),
    .fundReactPwr(fundReactPwr), .pulse_out_1(pulse_out_1), .pulse_out_2(pulse_out_2),
    .pulse_out_3(pulse_out_3), .energyCapture(energyCapture), .pathSum(pathSum),
    .phaseCompValue(phaseCompValue), .phaseCompLag(phaseCompLag));

  always @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      pulseCnt[i] <= cntOn ? pulseCnt[i] + {31'h0, pins[i] === 1'b1} : 32'h0;
      capCnt[i] <= cntOn ? capCnt[i] + {31'h0, energyCapture[i] === 1'b1} : 32'h0;
    end
  end

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, {14'h0, idx, 2'h0}, d, q);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, {14'h0, idx, 2'h0}, 32'h0, q);
    chk(q, e);
  endtask
  // twenty samples at two units a step against a threshold of four
  task automatic window(input logic [2:0] en, input logic [2:0] cap);
    repeat (6) @(posedge clk_sys);
    cntOn <= 1'b1;
    repeat (20) @(posedge clk_sys);
    cntOn <= 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      chk(pulseCnt[i], en[i] ? 32'd10 : 32'd0);
      chk(capCnt[i], cap[i] ? 32'd10 : 32'd0);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d n_mismatch=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    rdc(`POC_IDX_PULSE_CFG, 32'h0ea0);
    rdc(`POC_IDX_PHASE_B, 32'h0);
    rdc(`POC_IDX_COMP_MODE, 32'h1ff);
    chk({22'h0, phaseCompValue[2]}, 32'h0);
  endtask
  task automatic t_pulse;
    wr(`POC_IDX_COMP_MODE, 32'h049);
    for (int i = 0; i < 3; i++) begin
      totActPwr[i] <= (i == 0) ? 24'sd2 : 24'sd100;
      apparentPwr[i] <= 24'sd0;
      fundActPwr[i] <= 24'sd0;
      fundReactPwr[i] <= 24'sd0;
    end
    powerValid <= 1'b1;
    window(3'b000, 3'b000);
    wr(`POC_IDX_PULSE_CFG, 32'h6a00);
    window(3'b010, 3'b110);
    wr(`POC_IDX_PULSE_CFG, 32'h1400);
    window(3'b101, 3'b001);
  endtask
  task automatic t_fields;
    wr(`POC_IDX_PULSE_CFG, 32'hfffffe24);
    rdc(`POC_IDX_PULSE_CFG, 32'h7e24);
    wr(`POC_IDX_PHASE_A, 32'hfffffc05);
    rdc(`POC_IDX_PHASE_A, 32'h0005);
    chk({22'h0, phaseCompValue[0]}, 32'h5);
    wr(16'he611, 32'h1234);
    rdc(16'he611, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
  endtask
  task automatic t_alias;
    for (int i = 0; i < 8; i++) begin
      wr(16'(`POC_IDX_PHASE_A + i % 3), {22'h0, TV[i]});
      repeat (2) @(posedge clk_sys);
      chk({22'h0, phaseCompValue[i % 3]}, {22'h0, TE[i]});
      chk({31'h0, phaseCompLag[i % 3]}, {31'h0, TL[i]});
    end
  endtask
  task automatic t_sum;
    logic [2:0] code [4];
    code = '{3'h0, 3'h2, 3'h3, 3'h4};
    wr(`POC_IDX_COMP_MODE, 32'h1dd);
    for (int i = 0; i < 3; i++) begin
      totActPwr[i] <= (i == 0) ? 24'sd1 : (i == 1) ? 24'sd10 : 24'sd100;
      apparentPwr[i] <= (i == 0) ? 24'sd2 : (i == 1) ? 24'sd20 : 24'sd200;
      fundActPwr[i] <= (i == 0) ? 24'sd3 : (i == 1) ? 24'sd30 : 24'sd300;
      fundReactPwr[i] <= (i == 0) ? 24'sd4 : (i == 1) ? 24'sd40 : 24'sd400;
    end
    for (int k = 0; k < 4; k++) begin
      wr(`POC_IDX_PULSE_CFG, {23'h0, code[k], code[k], code[k]} | 32'h0e00);
      repeat (4) @(posedge clk_sys);
      chk({6'h0, pathSum[0]}, (k + 1) * 101);
      chk({6'h0, pathSum[1]}, (k + 1) * 11);
      chk({6'h0, pathSum[2]}, (k + 1) * 111);
    end
    // no phase, then every phase, on path 1
    wr(`POC_IDX_PULSE_CFG, 32'h0e00);
    wr(`POC_IDX_COMP_MODE, 32'h1f8);
    repeat (4) @(posedge clk_sys);
    chk({6'h0, pathSum[0]}, 32'h0);
    wr(`POC_IDX_COMP_MODE, 32'h007);
    repeat (4) @(posedge clk_sys);
    chk({6'h0, pathSum[0]}, 32'd111);
    chk({6'h0, pathSum[1]}, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_pulse();
    t_fields();
    t_alias();
    t_sum();
    finish_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
